// [shared/cwdt_defs.svh]
`ifndef CWDT_DEFS_SVH
`define CWDT_DEFS_SVH

// ****************************************************************
// Control register location and reset image
// ****************************************************************
`define CWDT_CTRL_ADDR 8'hC0
`define CWDT_CTRL_RESET 8'h10

// ****************************************************************
// Control register field positions
// ****************************************************************
`define CWDT_SEL_MSB 7
`define CWDT_SEL_LSB 4
`define CWDT_RESP_BIT 3
`define CWDT_FLAG_BIT 2
`define CWDT_ARM_BIT 1
`define CWDT_UNLOCK_BIT 0

// ****************************************************************
// Timing in crystal periods
// ****************************************************************
`define CWDT_XTAL_HZ 32768
`define CWDT_BASE_TICKS 16'h0200
`define CWDT_SEL_MAX_TIMED 4'h7
`define CWDT_SEL_IMMEDIATE 4'h8

`endif

// [shared/cwdt_pkg.sv]
package cwdt_pkg;

  // ****************************************************************
  // Special-function bus request from the core
  // ****************************************************************
  typedef struct packed {
    logic rd;           // Byte read strobe
    logic wr;           // Byte write strobe
    logic [7:0] addr;   // Byte address
    logic [7:0] wdata;  // Byte write data
    logic bit_wr;       // Single-bit write strobe
    logic [7:0] bit_addr; // Bit address
    logic bit_val;      // Bit value written
  } cwdt_sfr_req_t;

  // Timeout response kinds
  typedef enum logic {
    CWDT_RESP_RESET = 1'b0,
    CWDT_RESP_IRQ = 1'b1
  } cwdt_resp_t;

endpackage

// [src/cwdt_xtal_tick.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Crystal edge detector: three stages, level accepted on agreement
// ****************************************************************
module cwdt_xtal_tick (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic xtal_in,
  output logic tick_out
);

  logic s1_r; // Metastability catcher, read only by s2_r
  logic s2_r; // Second stage
  logic s3_r; // Third stage
  logic lvl_r; // Accepted crystal level

  // Shift chain
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce_in) begin
      s1_r <= xtal_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level change counts only when stages two and three agree
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      lvl_r <= 1'b0;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      tick_out <= 1'b0;
      if (s2_r == s3_r && s3_r != lvl_r) begin
        lvl_r <= s3_r;
        tick_out <= s3_r; // One pulse per rising crystal edge
      end
    end else begin
      tick_out <= 1'b0; // Frozen: no stale tick replayed
    end
  end

endmodule

`default_nettype wire

// [src/cwdt_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cwdt_defs.svh"

module cwdt_top #(
  parameter int CNT_W = 16 // Counter width, covers 512 << 7
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic xtal_in,
  input wire cwdt_pkg::cwdt_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  output logic wd_reset_out,
  output logic wd_irq_out,
  output logic [7:0] ctrl_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [3:0] sel_r; // Timeout select
  cwdt_pkg::cwdt_resp_t resp_r; // Response select
  logic flag_r; // Timeout flag
  logic arm_r; // Watchdog armed
  logic unlock_r; // Write unlock, lives for one access
  logic clr_pend_r; // Counter clear waiting for a crystal tick
  logic [CNT_W-1:0] cnt_r; // Crystal tick counter
  logic tick_w; // One-cycle crystal rising edge

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Register image as software sees it
  function automatic logic [7:0] ctrl_image(
    input logic [3:0] sel,
    input logic resp,
    input logic flag,
    input logic arm,
    input logic unl
  );
    ctrl_image = {sel, resp, flag, arm, unl};
  endfunction

  // Replace one bit of a byte
  function automatic logic [7:0] put_bit(
    input logic [7:0] old,
    input logic [2:0] idx,
    input logic val
  );
    logic [7:0] res;
    res = old;
    res[idx] = val;
    put_bit = res;
  endfunction

  cwdt_xtal_tick u_tick (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .xtal_in(xtal_in),
    .tick_out(tick_w)
  );

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic [7:0] cur_w; // Current image
  logic byte_hit_w; // Byte write to our address
  logic bit_hit_w; // Bit write inside our bit range
  logic unlock_set_w; // Bit set of the unlock bit
  logic any_acc_w; // Any bus access, ends an unlock window
  logic wr_ok_w; // Write accepted
  logic [7:0] new_w; // Value that an accepted write leaves
  logic [CNT_W-1:0] lim_w; // Last count of the period
  logic timed_w; // Select is a timed code
  logic timeout_w; // Timeout this cycle

  assign cur_w = ctrl_image(sel_r, resp_r, flag_r, arm_r, unlock_r);
  assign byte_hit_w = sfr_req_in.wr && sfr_req_in.addr == `CWDT_CTRL_ADDR;
  // Bit addresses C0H..C7H map onto this register
  assign bit_hit_w = sfr_req_in.bit_wr &&
    sfr_req_in.bit_addr[7:3] == `CWDT_CTRL_ADDR >> 3;
  assign unlock_set_w = bit_hit_w && sfr_req_in.bit_val &&
    sfr_req_in.bit_addr[2:0] == 3'(`CWDT_UNLOCK_BIT);
  assign any_acc_w = sfr_req_in.rd || sfr_req_in.wr || sfr_req_in.bit_wr;
  // Only the access right after the unlock is taken
  assign wr_ok_w = ce_in && unlock_r && (byte_hit_w ||
    (bit_hit_w && !unlock_set_w));
  assign new_w = sfr_req_in.wr ? sfr_req_in.wdata :
    put_bit(cur_w, sfr_req_in.bit_addr[2:0], sfr_req_in.bit_val);

  // Period is 512 ticks doubled per select step
  assign lim_w = (CNT_W'(`CWDT_BASE_TICKS) << sel_r[2:0]) - CNT_W'(1);
  assign timed_w = sel_r <= `CWDT_SEL_MAX_TIMED; // Reserved codes idle
  assign timeout_w = ce_in && tick_w && arm_r && timed_w &&
    !clr_pend_r && cnt_r == lim_w;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  // Select and response, loaded only by accepted writes
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sel_r <= 4'(`CWDT_CTRL_RESET >> `CWDT_SEL_LSB); // Image 10H
      resp_r <= cwdt_pkg::CWDT_RESP_RESET;
    end else if (wr_ok_w) begin
      sel_r <= new_w[`CWDT_SEL_MSB:`CWDT_SEL_LSB];
      resp_r <= cwdt_pkg::cwdt_resp_t'(new_w[`CWDT_RESP_BIT]);
    end
  end

  // Timeout flag: set wins over a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      flag_r <= 1'b0; // Hardware reset clears it
    end else if (ce_in) begin
      if (timeout_w || wd_reset_out) begin
        flag_r <= 1'b1; // own reset never clears it
      end else if (wr_ok_w && !new_w[`CWDT_FLAG_BIT]) begin
        flag_r <= 1'b0; // Writing 0 clears, writing 1 is ignored
      end
    end
  end

  // Arm bit
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      arm_r <= 1'b0;
    end else if (ce_in) begin
      if (timeout_w && resp_r == cwdt_pkg::CWDT_RESP_RESET) begin
        arm_r <= 1'b0; // Reset response disarms
      end else if (wr_ok_w) begin
        arm_r <= new_w[`CWDT_ARM_BIT];
      end
    end
  end

  // Unlock window lasts exactly one following access
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      unlock_r <= 1'b0;
    end else if (ce_in && any_acc_w) begin
      unlock_r <= unlock_set_w;
    end
  end

  // ****************************************************************
  // Counter, crystal side
  // ****************************************************************
  // The counter clear from an arm write is parked until the next tick, while
  // arm_r loads at once, so that a clear never lands mid-count between two crystal edges
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      clr_pend_r <= 1'b1;
    end else if (ce_in) begin
      if (wr_ok_w && new_w[`CWDT_ARM_BIT]) begin
        clr_pend_r <= 1'b1; // Re-arm clears the counter
      end else if (tick_w) begin
        clr_pend_r <= 1'b0;
      end
    end
  end

  // Count only on crystal edges
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
    end else if (ce_in && tick_w) begin
      if (clr_pend_r || !arm_r || timeout_w) begin
        cnt_r <= '0; // Periodic restart after a timeout
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Reset and interrupt pulses, one enabled clock each, held while ce_in is low
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      wd_reset_out <= 1'b0;
      wd_irq_out <= 1'b0;
    end else if (ce_in) begin
      // Immediate code with arm set resets at once
      wd_reset_out <= (timeout_w &&
        resp_r == cwdt_pkg::CWDT_RESP_RESET) || (wr_ok_w &&
        new_w[`CWDT_SEL_MSB:`CWDT_SEL_LSB] == `CWDT_SEL_IMMEDIATE &&
        new_w[`CWDT_ARM_BIT]);
      wd_irq_out <= timeout_w &&
        resp_r == cwdt_pkg::CWDT_RESP_IRQ;
    end
  end

  // Read data, registered one clock after the strobe
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (ce_in && sfr_req_in.rd) begin
      sfr_rdata_out <= (sfr_req_in.addr == `CWDT_CTRL_ADDR) ?
        cur_w : 8'h00;
    end
  end

  // Register image mirror
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ctrl_out <= `CWDT_CTRL_RESET;
    end else if (ce_in) begin
      ctrl_out <= cur_w;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_flag_on_timeout: assert property (@(posedge clock_in)
    disable iff (!resetn_in) timeout_w |=> flag_r)
    else $error("timeout did not set flag");

  a_reset_resp: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    timeout_w && resp_r == cwdt_pkg::CWDT_RESP_RESET
    |=> wd_reset_out && !wd_irq_out && !arm_r)
    else $error("reset response wrong");

  a_irq_resp: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    timeout_w && resp_r == cwdt_pkg::CWDT_RESP_IRQ
    |=> wd_irq_out && !wd_reset_out && arm_r)
    else $error("interrupt response wrong");

  a_periodic_restart: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    timeout_w && resp_r == cwdt_pkg::CWDT_RESP_IRQ |=> cnt_r == '0)
    else $error("counter not restarted");

  a_locked_write: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    ce_in && byte_hit_w && !unlock_r |=> $stable(sel_r) && $stable(resp_r))
    else $error("locked write took effect");

  a_flag_kept: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    flag_r && !(wr_ok_w && !new_w[`CWDT_FLAG_BIT]) |=> flag_r)
    else $error("flag lost without clear");

  a_immediate_rst: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    wr_ok_w && new_w[7:4] == `CWDT_SEL_IMMEDIATE && new_w[1]
    |=> wd_reset_out ##1 !wd_reset_out || !ce_in)
    else $error("immediate reset missing");

  a_rearm_clear: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    wr_ok_w && new_w[`CWDT_ARM_BIT] |=> clr_pend_r && arm_r)
    else $error("re-arm did not clear");

  a_tick_only: assert property (@(posedge clock_in)
    disable iff (!resetn_in) !(ce_in && tick_w) |=> $stable(cnt_r))
    else $error("counter moved without tick");

  a_reset_image: assert property (@(posedge clock_in)
    disable iff (!resetn_in) $rose(resetn_in) |-> cur_w == 8'h10)
    else $error("reset image not 10H");

endmodule

`default_nettype wire

// [tb/test_crystal_watchdog_timer.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Self-checking bench for the crystal watchdog
// ****************************************************************
module test_crystal_watchdog_timer;
  localparam int XT_HALF = 4; // Core cycles per crystal half period
  logic clock_in; // Core clock, 50 MHz
  logic resetn_in; // Hardware reset, active low
  logic ce_in; // Clock enable
  logic xtal_in; // Fast stand-in crystal, keeps the run short
  cwdt_pkg::cwdt_sfr_req_t req; // Register bus request
  logic [7:0] sfr_rdata_out;
  logic wd_reset_out;
  logic wd_irq_out;
  logic [7:0] ctrl_out;
  int bad_count, num_checks, rst_cnt, irq_cnt, n, k;
  logic [7:0] a;

  cwdt_top dut (.clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .xtal_in(xtal_in), .sfr_req_in(req), .sfr_rdata_out(sfr_rdata_out),
    .wd_reset_out(wd_reset_out), .wd_irq_out(wd_irq_out),
    .ctrl_out(ctrl_out));

  // ****************************************************************
  // Clocks and pulse counters
  // ****************************************************************
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // Crystal stays regular so timeout intervals are exact
  initial begin
    xtal_in = 1'b0;
    forever begin
      repeat (XT_HALF) @(posedge clock_in);
      xtal_in <= ~xtal_in;
    end
  end
  // Count pulses so none slips past a waiting task
  always @(posedge clock_in) begin
    if (wd_reset_out === 1'b1) rst_cnt++;
    if (wd_irq_out === 1'b1) irq_cnt++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic int period_cyc(int sel);
    return (512 << sel) * 2 * XT_HALF; // Core cycles in one timeout
  endfunction

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One bus access, held for one taking edge
  task automatic acc(bit r, bit w, logic [7:0] ad, logic [7:0] d,
                     bit b, logic [7:0] ba, bit bv);
    @(posedge clock_in);
    req <= '{rd: r, wr: w, addr: ad, wdata: d, bit_wr: b, bit_addr: ba,
             bit_val: bv};
    @(posedge clock_in);
    req <= '0;
  endtask

  // Unlock, then the protected byte write
  task automatic wrc(logic [7:0] d);
    acc(0, 0, 8'h00, 8'h00, 1, 8'hC0, 1);
    acc(0, 1, 8'hC0, d, 0, 8'h00, 0);
  endtask

  task automatic rd_chk(logic [7:0] ad, logic [7:0] exp);
    acc(1, 0, ad, 8'h00, 0, 8'h00, 0);
    #1;
    chk("rdata", sfr_rdata_out, exp);
  endtask

  // Bounded wait for the next reset or interrupt pulse
  task automatic wait_pulse(bit irq, int lim, output int cyc);
    int c0;
    c0 = irq ? irq_cnt : rst_cnt;
    cyc = 0;
    while ((irq ? irq_cnt : rst_cnt) == c0 && cyc < lim) begin
      @(posedge clock_in);
      #1;
      cyc++;
    end
    if ((irq ? irq_cnt : rst_cnt) == c0) begin
      bad_count++;
      $display("MISMATCH pulse wait expected pulse seen none");
      stop_test();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    resetn_in = 1'b0;
    ce_in = 1'b1;
    req = '0;
    bad_count = 0;
    num_checks = 0;
    rst_cnt = 0;
    irq_cnt = 0;
    void'($urandom(32'hF0E6AD8B));
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    #1;
    chk("ctrl reset", ctrl_out, 8'h10);
    rd_chk(8'hC0, 8'h10);
    a = 8'($urandom());
    if (a == 8'hC0) a = 8'hC1;
    rd_chk(a, 8'h00);
    // Writes without a fresh unlock are dropped
    acc(0, 1, 8'hC0, 8'($urandom()) | 8'h02, 0, 8'h00, 0);
    acc(0, 0, 8'h00, 8'h00, 1, 8'hC0, 1);
    acc(1, 0, a, 8'h00, 0, 8'h00, 0);
    acc(0, 1, 8'hC0, 8'h82, 0, 8'h00, 0);
    repeat (2) @(posedge clock_in);
    #1;
    chk("ctrl locked", ctrl_out & 8'hFE, 8'h10);
    // Interrupt response as periodic timer, several selects
    for (int s = 0; s < 3; s++) begin
      wrc({4'(s), 4'hA});
      k = rst_cnt;
      wait_pulse(1, period_cyc(s) + 200, n);
      wait_pulse(1, period_cyc(s) + 200, n);
      chk("period", 8'(n / period_cyc(0)), 8'(1 << s));
      chk("period rem", 8'(n % period_cyc(0)), 8'h00);
      repeat (2) @(posedge clock_in);
      #1;
      chk("sel field", 8'(ctrl_out[7:4]), 8'(s));
      chk("flag irq", 8'(ctrl_out[2]), 8'h01);
      chk("no reset", 8'(rst_cnt - k), 8'h00);
    end
    // Single-bit clear of the flag
    acc(0, 0, 8'h00, 8'h00, 1, 8'hC0, 1);
    acc(0, 0, 8'h00, 8'h00, 1, 8'hC2, 0);
    repeat (2) @(posedge clock_in);
    #1;
    chk("flag clear", 8'(ctrl_out[2]), 8'h00);
    // Frozen clock enable: neither unlock nor write is taken
    @(posedge clock_in);
    ce_in <= 1'b0;
    acc(0, 0, 8'h00, 8'h00, 1, 8'hC0, 1);
    acc(0, 1, 8'hC0, 8'h00, 0, 8'h00, 0);
    @(posedge clock_in);
    ce_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    chk("ce frozen", ctrl_out, 8'h2A);
    // Reset response, kicked in time at random moments
    k = rst_cnt;
    wrc(8'h02);
    for (int i = 0; i < 4; i++) begin
      repeat (2000 + ($urandom() % 1500)) @(posedge clock_in);
      wrc(8'h02);
    end
    chk("kicked", 8'(rst_cnt - k), 8'h00);
    wait_pulse(0, period_cyc(0) + 200, n);
    repeat (2) @(posedge clock_in);
    #1;
    chk("after wd reset", ctrl_out, 8'h04);
    // Immediate reset code
    wrc(8'h82);
    wait_pulse(0, 4, n);
    repeat (3) @(posedge clock_in);
    #1;
    chk("flag immediate", 8'(ctrl_out[2]), 8'h01);
    // Reserved select arms but never times out; flag write of 1 ignored
    k = rst_cnt;
    wrc(8'h96);
    repeat (period_cyc(0) + 200) @(posedge clock_in);
    #1;
    chk("reserved idle", 8'(rst_cnt - k), 8'h00);
    chk("reserved sel", ctrl_out, 8'h96);
    // Hardware reset clears flag and arm
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    #1;
    chk("ctrl hw reset", ctrl_out, 8'h10);
    stop_test();
  end
endmodule

`default_nettype wire
